// >>> rtl/icr_pkg.sv
// Constants for the interrupt and control register bank.
// Assumes a simple synchronous register port with byte enables.
// Operation
// R1 - Reset clears every interrupt register bit to zero.
// R2 - Both registers accept byte-wide or halfword-wide reads and writes.
// R3 - Bit 0 enables interrupts; requests only while it is one.
// R4 - Writing zero to enable disables interrupts and drops the request.
// R5 - Bit 1 shows pending; pending drives the request only when enabled.
// R6 - Interrupt register bits 14 to 2 read as zero.
// R7 - Writing one to bit 15 withdraws the current request.
// R8 - A raised request holds until release or enable cleared.
// R9 - Host service routine writes release to remove the pending request.
// R10 - Reset clears every control register bit to zero.
// R11 - Control bit 0: zero two's complement, one straight binary output.
// R12 - Control bits 2,1: 01 input, 10 output, 00 or 11 disabled.
// R13 - System sets one trigger master, others inputs, pins tied together.
// R14 - Software should keep the trigger disabled when not needed.
// R15 - Release bit is a strobe, never stored, reads back as zero.
package icr_pkg;
	localparam logic [7:0]  ICR_OFS_IRQ      = 8'h00;
	localparam logic [7:0]  ICR_OFS_CTRL     = 8'h04;
	localparam int          ICR_BIT_EN       = 0;
	localparam int          ICR_BIT_PEND     = 1;
	localparam int          ICR_BIT_REL      = 15;
	localparam int          ICR_BIT_FMT      = 0;
	localparam int          ICR_BIT_TRG_LO   = 1;
	localparam int          ICR_BIT_TRG_HI   = 2;
	localparam logic [2:0]  ICR_CTRL_MASK    = 3'h7;
	localparam logic [15:0] ICR_RESET_VAL    = 16'h0000;
	localparam logic [1:0]  ICR_TRG_IN       = 2'h1;
	localparam logic [1:0]  ICR_TRG_OUT      = 2'h2;
	localparam logic [15:0] ICR_SIGN_BIT     = 16'h8000;
endpackage

// >>> rtl/icr_regs.sv
// Interrupt and control register bank with trigger pin steering.
// Assumes a one-cycle register port; event source and converter outside.
`timescale 1ns/1ns
module icr_regs
	import icr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [1:0]  reg_be,
	input  wire logic [15:0] reg_wdata,
	output logic [15:0]      reg_rdata_q,
	input  wire logic        irq_event,
	output logic             irq_req_q,
	input  wire logic [15:0] conv_data,
	output logic [15:0]      result_q,
	input  wire logic        trig_in,
	output logic             trig_out_q,
	output logic             trig_oe_n_q,
	output logic             trig_seen_q
);
	// ==========================================================
	// Decode
	logic        hit_irq;
	logic        hit_ctrl;
	logic        wr_lo;
	logic        wr_hi;
	logic        en_q;
	logic        pend_q;
	logic [2:0]  ctrl_q;
	logic        trig_lvl;
	logic        trig_prev_q;

	assign hit_irq  = (reg_addr == ICR_OFS_IRQ);
	assign hit_ctrl = (reg_addr == ICR_OFS_CTRL);
	assign wr_lo    = reg_wr && reg_be[0]; // [R2]
	assign wr_hi    = reg_wr && reg_be[1]; // [R2]

	// ==========================================================
	// Interrupt register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			en_q <= ICR_RESET_VAL[ICR_BIT_EN]; // [R1]
		end else if (hit_irq && wr_lo) begin
			en_q <= reg_wdata[ICR_BIT_EN]; // [R3] [R4]
		end
	end

	// Event wins over a release in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pend_q <= ICR_RESET_VAL[ICR_BIT_PEND]; // [R1]
		end else if (irq_event) begin
			pend_q <= 1'b1;
		end else if (hit_irq && wr_hi && reg_wdata[ICR_BIT_REL]) begin
			pend_q <= 1'b0; // [R7] [R9] [R15]
		end
	end

	// Request follows next state so release and disable act at once
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq_req_q <= 1'b0; // [R1]
		end else if (hit_irq && wr_lo && !reg_wdata[ICR_BIT_EN]) begin
			irq_req_q <= 1'b0; // [R4] [R8]
		end else if (irq_event) begin
			irq_req_q <= en_q || (hit_irq && wr_lo); // [R3] [R5]
		end else if (hit_irq && wr_hi && reg_wdata[ICR_BIT_REL]) begin
			irq_req_q <= 1'b0; // [R7] [R8]
		end else begin
			irq_req_q <= pend_q && (en_q || (hit_irq && wr_lo)); // [R5]
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_q <= ICR_RESET_VAL[2:0]; // [R10]
		end else if (hit_ctrl && wr_lo) begin
			// Upper mode fields live elsewhere; only low bits here
			ctrl_q <= reg_wdata[2:0] & ICR_CTRL_MASK; // [R2]
		end
	end

	// ==========================================================
	// Read path
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			reg_rdata_q <= ICR_RESET_VAL;
		end else if (reg_rd && hit_irq) begin
			reg_rdata_q <= ICR_RESET_VAL; // [R6] [R15]
			reg_rdata_q[ICR_BIT_EN]   <= en_q;
			reg_rdata_q[ICR_BIT_PEND] <= pend_q; // [R5]
		end else if (reg_rd && hit_ctrl) begin
			reg_rdata_q <= {13'h0000, ctrl_q};
		end else begin
			// Unmapped reads return zero
			reg_rdata_q <= ICR_RESET_VAL;
		end
	end

	// ==========================================================
	// Output data format
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			result_q <= ICR_RESET_VAL;
		end else if (ctrl_q[ICR_BIT_FMT]) begin
			result_q <= conv_data ^ ICR_SIGN_BIT; // [R11]
		end else begin
			result_q <= conv_data; // [R11]
		end
	end

	// ==========================================================
	// Trigger pin
	icr_sync u_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.pin_in  (trig_in),
		.level_q (trig_lvl)
	);

	// Out-driven level taken from irq_event while in output mode
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			trig_oe_n_q <= 1'b1;
			trig_out_q  <= 1'b0;
			trig_prev_q <= 1'b0;
			trig_seen_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_lvl;
			trig_oe_n_q <= (ctrl_q[ICR_BIT_TRG_HI:ICR_BIT_TRG_LO]
				!= ICR_TRG_OUT); // [R12] [R13]
			trig_out_q  <= irq_event &&
				(ctrl_q[ICR_BIT_TRG_HI:ICR_BIT_TRG_LO] == ICR_TRG_OUT);
			// Disabled input ignores noise on the pin
			trig_seen_q <= trig_lvl && !trig_prev_q &&
				(ctrl_q[ICR_BIT_TRG_HI:ICR_BIT_TRG_LO] == ICR_TRG_IN); // [R12] [R14]
		end
	end
endmodule

// >>> rtl/icr_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ns
module icr_sync
	import icr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic pin_in,
	output logic      level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only once the late stages agree
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// >>> verif/icr_checker.sv
// Port checker for the register bank.
// Bound onto icr_regs from the bench top file.
`timescale 1ns/1ns
module icr_checker(
	input logic        sys_clk,
	input logic        reset_n,
	input logic [7:0]  reg_addr,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [1:0]  reg_be,
	input logic [15:0] reg_wdata,
	input logic [15:0] reg_rdata_q,
	input logic        irq_event,
	input logic        irq_req_q,
	input logic [15:0] conv_data,
	input logic [15:0] result_q,
	input logic        trig_oe_n_q
);
// ======================
// Properties
default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);
sequence s_irq_wr; reg_wr && reg_addr == 8'h00; endsequence
sequence s_ctl_wr; reg_wr && reg_addr == 8'h04 && reg_be[0]; endsequence
AST_RST: assert property (disable iff (1'b0) !reset_n |=>
	!irq_req_q && reg_rdata_q == 16'h0000) else $error("reset state");
AST_REL: assert property (s_irq_wr ##0 reg_be[1] &&
	reg_wdata[15] && !irq_event |=> !irq_req_q) else $error("release");
AST_DIS: assert property (s_irq_wr ##0 reg_be[0] &&
	!reg_wdata[0] |=> !irq_req_q) else $error("disable");
AST_HOLD: assert property (irq_req_q && !reg_wr |=>
	irq_req_q) else $error("request dropped");
AST_UNUSED: assert property (reg_rd && reg_addr == 8'h00 |=>
	reg_rdata_q[15:2] == 14'h0000) else $error("unused bits");
// Past write excluded; request and register update on the same edge
AST_PEND: assert property (reg_rd && !$past(reg_wr) &&
	reg_addr == 8'h00 && irq_req_q |=> reg_rdata_q[1:0] == 2'h3)
	else $error("pending read");
AST_OE: assert property (s_ctl_wr ##0 reg_wdata[2:1] == 2'h2
	|-> ##[1:2] !trig_oe_n_q) else $error("trigger drive");
AST_FMT: assert property (s_ctl_wr ##0 reg_wdata[0] ##1
	!reg_wr [*2] |=> result_q == ($past(conv_data) ^ 16'h8000))
	else $error("format");
endmodule

// >>> verif/icr_trg_peer.sv
// Peer board acting as trigger master on the shared pin.
// Assumes fire is a level raised by the bench.
`timescale 1ns/1ns
module icr_trg_peer(
	input wire logic fire,
	output logic     trig_in
);
// ======================
// Pin quiet outside pulses, no false triggers
initial trig_in = 1'b0;
// Lone master drives one pulse
always @(posedge fire) begin
	trig_in = 1'b1;
	#370 trig_in = 1'b0;
end
endmodule

// >>> verif/interrupt_and_control_regs_tb_top.sv
// Bench for the register bank with a peer trigger board.
// Drives inputs 1 ns after each rising edge.
`timescale 1ns/1ns
module interrupt_and_control_regs_tb_top;
logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
logic irq_event = 0, fire = 0, irq_req_q, trig_in;
logic trig_out_q, trig_oe_n_q, trig_seen_q;
logic [7:0] reg_addr = 8'h00;
logic [1:0] reg_be = 2'h0;
logic [15:0] reg_wdata = 16'h0000, conv_data = 16'h0000;
logic [15:0] reg_rdata_q, result_q, rdata;
int err_count = 0, compares = 0, seen = 0;
logic [41:0] rows [6] = '{{8'h00, 2'h3, 16'hFFFF, 16'h0001},
	{8'h00, 2'h1, 16'h0000, 16'h0000}, {8'h04, 2'h3, 16'hFFFF, 16'h0007},
	{8'h04, 2'h2, 16'h0000, 16'h0007}, {8'h04, 2'h1, 16'h0002, 16'h0002},
	{8'h10, 2'h3, 16'hFFFF, 16'h0000}};
always #50 sys_clk = ~sys_clk;
icr_regs DUT(.*);
icr_trg_peer PEER(.fire(fire), .trig_in(trig_in));
always @(negedge sys_clk) if (trig_seen_q) seen++;
task chk(input logic [15:0] g, e);
	compares++;
	if (g !== e) begin
		err_count++;
		$display("BAD t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task step; @(posedge sys_clk) #1; endtask
task wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
	step; reg_addr = a; reg_be = b; reg_wdata = d; reg_wr = 1; step; reg_wr = 0;
endtask
task rd(input logic [7:0] a);
	step; reg_addr = a; reg_rd = 1; step; reg_rd = 0; rdata = reg_rdata_q;
endtask
task ev; step; irq_event = 1; step; irq_event = 0; step; endtask
task give_verdict;
	if (err_count == 0 && compares > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
initial begin
	#100000 err_count++;
	give_verdict;
end
initial begin
	repeat (16) step; reset_n = 1;
	foreach (rows[i]) begin
		wr(rows[i][41:34], rows[i][33:32], rows[i][31:16]);
		rd(rows[i][41:34]); chk(rdata, rows[i][15:0]);
	end
	ev; rd(8'h00); chk(rdata, 16'h0002);
	chk({15'h0, irq_req_q}, 16'h0000);
	wr(8'h00, 2'h1, 16'h0001); step; chk({15'h0, irq_req_q}, 16'h0001);
	rd(8'h00); chk(rdata, 16'h0003);
	wr(8'h00, 2'h2, 16'h8000); step;
	chk({15'h0, irq_req_q}, 16'h0000);
	rd(8'h00); chk(rdata, 16'h0001);
	ev; chk({15'h0, irq_req_q}, 16'h0001);
	wr(8'h00, 2'h1, 16'h0000); step; chk({15'h0, irq_req_q}, 16'h0000);
	wr(8'h04, 2'h1, 16'h0004); step; step; chk({15'h0, trig_oe_n_q}, 16'h0000);
	irq_event = 1;
	step;
	chk({15'h0, trig_out_q}, 16'h0001);
	irq_event = 0;
	step;
	chk({15'h0, trig_out_q}, 16'h0000);
	wr(8'h04, 2'h1, 16'h0002); fire = 1; repeat (12) step;
	chk(16'(seen), 16'h0001);
	chk({15'h0, trig_oe_n_q}, 16'h0001);
	conv_data = 16'h1234; wr(8'h04, 2'h1, 16'h0001); step; step;
	chk(result_q, 16'h9234);
	wr(8'h04, 2'h1, 16'h0000); step; step; chk(result_q, 16'h1234);
	ev; wr(8'h04, 2'h1, 16'h0007); reset_n = 0; step; reset_n = 1;
	rd(8'h00); chk(rdata, 16'h0000);
	rd(8'h04); chk(rdata, 16'h0000);
	give_verdict;
end
endmodule
bind icr_regs icr_checker CHK(.*);
